// >>> common/wake_irq_pkg.sv
// shared constants for the wake interrupt flags and reset entry block
package wake_irq_pkg;
  localparam int          NUM_WAKE          = 6;
  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 32;
  // register byte offsets
  localparam logic [3:0]  OFF_WAKE_FLAGS    = 4'h0;
  localparam logic [3:0]  OFF_EXT_FLAGS     = 4'h4;
  localparam logic [3:0]  OFF_WAKE_CONFIG   = 4'h8;
  localparam logic [3:0]  OFF_ENABLE        = 4'hc;
  // field positions in the config register
  localparam int          CFG_EDGE_LSB      = 0;
  localparam int          CFG_EXT_EDGE_BIT  = 6;
  localparam int          CFG_FUNC_LSB      = 8;
  localparam int          CFG_EXT_FUNC_BIT  = 14;
  // field positions in the enable register
  localparam int          EN_EXT_BIT        = 0;
  localparam int          EN_WAKE_BIT       = 5;
  // reserved flag bits read as ones
  localparam logic [1:0]  WAKE_RSVD_VALUE   = 2'h3;
  localparam int          WAKE_RSVD_LSB     = 6;
  // reset vector location and width
  localparam logic [15:0] RESET_VEC_ADDR    = 16'h0000;
  localparam int          MEM_AW            = 4;
  // least reset hold from outside, system clocks
  localparam int          RESET_HOLD_CYCLES = 10;
  // reset entry sequencer states
  typedef enum logic [3:0] {
    ST_HALT  = 4'h1,
    ST_MASK  = 4'h2,
    ST_FETCH = 4'h4,
    ST_RUN   = 4'h8
  } entry_state_t;
endpackage : wake_irq_pkg

// >>> rtl/vector_rom.sv
// small vector memory with registered read data
`timescale 1ns/1ps
module vector_rom
  import wake_irq_pkg::*;
#(
  parameter int          AW        = MEM_AW,
  parameter logic [15:0] VEC_VALUE = 16'h0100
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [AW-1:0] addr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // fixed contents: the vector in big-endian order, rest zero
  always_comb begin
    for (int i = 0; i < (1<<AW); i++) begin
      mem[i] = 8'h00;
    end
    mem[0] = VEC_VALUE[15:8];
    mem[1] = VEC_VALUE[7:0];
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule : vector_rom

// >>> rtl/wake_irq_flags_reset_entry.sv
// wake and line-0 request flags, avalon slave, and reset entry sequencer
`timescale 1ns/1ps
// What this block does
// (RULE1) line-0 flag sets on chosen edge when pin is interrupt input; write 0 clears
// (RULE2) wake flag register bits 7 and 6 always read as one
// (RULE3) wake flags 5..0 set on chosen edge of their pin in interrupt mode
// (RULE4) writing 0 clears a wake flag; flags reset to zero
// (RULE5) reset pin low halts all processing at once
// (RULE6) reset returns all internal state and registers to initial values
// (RULE7) outside logic holds reset low at least ten clocks during operation
// (RULE8) at power-up outside logic holds reset until clock is stable
// (RULE9) on reset release the reset entry sequence begins
// (RULE10) first entry step sets the interrupt mask bit to one
// (RULE11) then vector read from bytes 0 and 1 loads program counter, run starts
// (RULE12) each pin's set edge is chosen individually, rising or falling
// (RULE13) a pin sets its flag only when its function is interrupt input
// (RULE14) one common enable masks all six wake requests toward the processor
// (RULE15) writing 1 keeps a flag; a new edge beats a same-cycle clear
module wake_irq_flags_reset_entry
  import wake_irq_pkg::*;
#(
  parameter int          NW        = NUM_WAKE,
  parameter logic [15:0] VEC_VALUE = 16'h0100
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   avs_response_err,
  input  wire logic [NW-1:0]     wake_line,
  input  wire logic              ext_int_line_0,
  output logic                   irq,
  output logic                   wake_irq_req,
  output logic                   ext0_irq_req,
  output logic                   interrupt_mask,
  output logic      [15:0]       program_counter,
  output logic                   cpu_run
);
  localparam int NP = NW + 1; // wake pins plus line 0

  // pin synchroniser stages: s1 only feeds s2
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic [NP-1:0] pin_s3;
  logic [NP-1:0] pin_level;

  // software registers
  logic [NW-1:0] wake_request_flags;
  logic          ext_line0_request_flag;
  logic [NW-1:0] wake_edge_select;
  logic          ext_edge_select;
  logic [NW-1:0] wake_pin_is_irq;
  logic          ext_pin_is_irq;
  logic          wake_common_enable;
  logic          ext_line0_enable;

  // bus handshake
  logic          acc_done;
  logic          rd_hit;
  logic          wr_hit;
  logic          addr_ok;

  // edge events and clears
  logic [NP-1:0] edge_sel_all;
  logic [NP-1:0] func_irq_all;
  logic [NP-1:0] pin_event;
  logic [NW-1:0] wake_clear;
  logic          ext_clear;

  // reset entry
  entry_state_t  state;
  entry_state_t  next_state;
  logic [1:0]    fetch_cnt;
  logic [MEM_AW-1:0] rom_addr;
  logic [7:0]    rom_data;

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= {ext_int_line_0, wake_line};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // filtered level follows only agreed values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_level[i] <= pin_s3[i];
        end
      end
    end
  end

  // edge detect per pin, gated by pin function
  assign edge_sel_all = {ext_edge_select, wake_edge_select};
  assign func_irq_all = {ext_pin_is_irq, wake_pin_is_irq};
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      // edge select 1 = rising, 0 = falling
      pin_event[i] = func_irq_all[i] &&                              // [RULE13]
                     (pin_s2[i] == pin_s3[i]) &&
                     (pin_s3[i] != pin_level[i]) &&
                     (pin_s3[i] == edge_sel_all[i]);                 // [RULE12]
    end
  end

  // one-wait-state slave: waitrequest low in the second cycle of a request
  assign avs_waitrequest = (avs_read || avs_write) && !acc_done;
  assign rd_hit          = avs_read && !avs_waitrequest;
  assign wr_hit          = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign addr_ok = (avs_address == OFF_WAKE_FLAGS) || (avs_address == OFF_EXT_FLAGS) ||
                   (avs_address == OFF_WAKE_CONFIG) || (avs_address == OFF_ENABLE);

  // acc_done marks the answer cycle and then drops for one idle cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (avs_read || avs_write) && !acc_done;
    end
  end

  // clears come from writing zero; writing one leaves the flag alone
  always_comb begin
    wake_clear = '0;
    ext_clear  = 1'b0;
    if (wr_hit && avs_address == OFF_WAKE_FLAGS) begin
      wake_clear = ~avs_writedata[NW-1:0];                           // [RULE4] [RULE15]
    end
    if (wr_hit && avs_address == OFF_EXT_FLAGS) begin
      ext_clear = ~avs_writedata[0];                                 // [RULE1]
    end
  end

  // sticky flags; a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request_flags     <= '0;                                  // [RULE4] [RULE6]
      ext_line0_request_flag <= 1'b0;
    end else begin
      wake_request_flags     <= (wake_request_flags & ~wake_clear) |
                                pin_event[NW-1:0];                   // [RULE3] [RULE15]
      ext_line0_request_flag <= (ext_line0_request_flag & ~ext_clear) |
                                pin_event[NW];                       // [RULE1] [RULE15]
    end
  end

  // configuration writes, low byte lanes only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_edge_select   <= '0;                                      // [RULE6]
      ext_edge_select    <= 1'b0;
      wake_pin_is_irq    <= '0;
      ext_pin_is_irq     <= 1'b0;
      wake_common_enable <= 1'b0;
      ext_line0_enable   <= 1'b0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == OFF_WAKE_CONFIG && avs_byteenable[0]) begin
        wake_edge_select <= avs_writedata[CFG_EDGE_LSB +: NW];
        ext_edge_select  <= avs_writedata[CFG_EXT_EDGE_BIT];
      end
      if (avs_address == OFF_WAKE_CONFIG && avs_byteenable[1]) begin
        wake_pin_is_irq <= avs_writedata[CFG_FUNC_LSB +: NW];
        ext_pin_is_irq  <= avs_writedata[CFG_EXT_FUNC_BIT];
      end
      if (avs_address == OFF_ENABLE && avs_byteenable[0]) begin
        wake_common_enable <= avs_writedata[EN_WAKE_BIT];
        ext_line0_enable   <= avs_writedata[EN_EXT_BIT];
      end
    end
  end

  // read data registered at the answer edge; unmapped reads zero plus error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata     <= '0;
      avs_response_err <= 1'b0;
    end else if ((avs_read || avs_write) && !acc_done) begin
      avs_readdata     <= '0;
      avs_response_err <= !addr_ok;
      if (avs_read) begin
        case (avs_address)
          OFF_WAKE_FLAGS: begin
            avs_readdata[WAKE_RSVD_LSB +: 2] <= WAKE_RSVD_VALUE;     // [RULE2]
            avs_readdata[NW-1:0]             <= wake_request_flags;
          end
          OFF_EXT_FLAGS: begin
            avs_readdata[0] <= ext_line0_request_flag;
          end
          OFF_WAKE_CONFIG: begin
            avs_readdata[CFG_EDGE_LSB +: NW] <= wake_edge_select;
            avs_readdata[CFG_EXT_EDGE_BIT]   <= ext_edge_select;
            avs_readdata[CFG_FUNC_LSB +: NW] <= wake_pin_is_irq;
            avs_readdata[CFG_EXT_FUNC_BIT]   <= ext_pin_is_irq;
          end
          OFF_ENABLE: begin
            avs_readdata[EN_WAKE_BIT] <= wake_common_enable;
            avs_readdata[EN_EXT_BIT]  <= ext_line0_enable;
          end
          default: begin
            avs_readdata <= '0;
          end
        endcase
      end
    end
  end

  // requests toward the processor; one common enable for all wake flags
  assign wake_irq_req = wake_common_enable && (|wake_request_flags);  // [RULE14]
  assign ext0_irq_req = ext_line0_enable && ext_line0_request_flag;
  assign irq          = wake_irq_req || ext0_irq_req;

  // reset entry state; async reset stops everything at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HALT;                                              // [RULE5]
    end else begin
      state <= next_state;
    end
  end

  // halt -> mask -> fetch two vector bytes -> run
  always_comb begin
    next_state = state;
    case (state)
      ST_HALT:  next_state = ST_MASK;                                // [RULE9]
      ST_MASK:  next_state = ST_FETCH;
      ST_FETCH: next_state = (fetch_cnt == 2'h3) ? ST_RUN : ST_FETCH;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_HALT;
    endcase
  end

  // fetch counter: addresses issued at count 0,1, data at 1,2, done at 3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_cnt <= 2'h0;
    end else if (state == ST_FETCH) begin
      fetch_cnt <= fetch_cnt + 2'h1;
    end
  end

  assign rom_addr = RESET_VEC_ADDR[MEM_AW-1:0] + {{(MEM_AW-1){1'b0}}, fetch_cnt[0]};

  vector_rom #(
    .AW        (MEM_AW),
    .VEC_VALUE (VEC_VALUE)
  ) u_vector_rom (
    .clk   (clk),
    .rst_n (rst_n),
    .addr  (rom_addr),
    .rdata (rom_data)
  );

  // mask set first; the vector is loaded high byte then low byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_mask  <= 1'b0;
      program_counter <= 16'h0000;
    end else begin
      if (state == ST_MASK) begin
        interrupt_mask <= 1'b1;                                      // [RULE10]
      end
      if (state == ST_FETCH && fetch_cnt == 2'h1) begin
        program_counter[15:8] <= rom_data;                           // [RULE11]
      end
      if (state == ST_FETCH && fetch_cnt == 2'h2) begin
        program_counter[7:0] <= rom_data;                            // [RULE11]
      end
    end
  end

  // processor may run only after the vector is in place
  assign cpu_run = (state == ST_RUN);                                // [RULE11]
endmodule : wake_irq_flags_reset_entry

// >>> verification/wake_irq_flags_reset_entry_tb.sv
// self-checking bench for the wake flags and reset entry block
`timescale 1ns/1ps
module wake_irq_flags_reset_entry_tb
  import wake_irq_pkg::*;
;
  localparam logic [15:0] VEC = 16'h2468;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest, avs_response_err, irq, wake_irq_req, ext0_irq_req;
  logic              interrupt_mask, cpu_run, ext_int_line_0, want_ext = 1'b0;
  logic [15:0]       program_counter;
  logic [5:0]        wake_line, want_wake = 6'h00, e, k;
  logic [16:0]       expq[$];
  int                miscompares = 0;
  int                n_compared = 0;

  always #25 clk = ~clk;

  wake_irq_flags_reset_entry #(.VEC_VALUE(VEC)) i_wake_irq_flags_reset_entry (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .wake_line(wake_line), .ext_int_line_0(ext_int_line_0),
    .irq(irq), .wake_irq_req(wake_irq_req), .ext0_irq_req(ext0_irq_req),
    .interrupt_mask(interrupt_mask), .program_counter(program_counter), .cpu_run(cpu_run));

  wake_pin_model i_wake_pin_model (.clk(clk), .want_wake(want_wake), .want_ext(want_ext),
    .wake_line(wake_line), .ext_int_line_0(ext_int_line_0));

  task automatic final_report();
    // a read whose answer never came still owes its comparison
    miscompares += expq.size();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // one compare for read results and output levels alike
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp

  // bus cycle: request held until waitrequest is seen low at a rising edge
  // no cycle count assumed: only the watchdog ends a stuck wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  // read: note the expected {err, low half} first, then run the cycle
  task automatic rd(input logic [3:0] a, input logic [16:0] exp);
    expq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // pins need a few clocks through the synchroniser before flags move
  task automatic pins(input logic [5:0] w, input logic x);
    want_wake <= w;
    want_ext  <= x;
    repeat (8) @(posedge clk);
  endtask : pins

  // read data checker: oldest note against what the slave returned
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
      cmp({avs_response_err, avs_readdata[15:0]}, expq.pop_front());

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    void'($urandom(74687));
    e = 6'($urandom);
    k = 6'($urandom);
    repeat (20) @(posedge clk);
    cmp({irq, cpu_run, interrupt_mask, program_counter[13:0]}, 17'h0);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp({interrupt_mask, program_counter}, {1'b1, VEC});
    // pin activity while pins are in port mode
    pins(6'h3f, 1'b1);
    pins(6'h00, 1'b0);
    rd(OFF_WAKE_FLAGS, 17'h00c0);
    rd(4'h2, 17'h10000);
    // arm wake pins on random edges and line 0 on falling, give the wrong edge, then the chosen one
    pins(e, 1'b0);
    bus(1'b1, OFF_WAKE_CONFIG, {17'h0, 1'b1, 6'h3f, 2'b00, e});
    pins(~e, 1'b1);
    rd(OFF_WAKE_FLAGS, 17'h00c0);
    rd(OFF_EXT_FLAGS, 17'h0000);
    pins(e, 1'b0);
    rd(OFF_WAKE_FLAGS, 17'h00ff);
    rd(OFF_EXT_FLAGS, 17'h0001);
    cmp({irq, wake_irq_req, ext0_irq_req}, 17'h0);
    bus(1'b1, OFF_ENABLE, 32'h21);
    cmp({irq, wake_irq_req, ext0_irq_req}, 17'h7);
    // ones keep, zeros clear
    bus(1'b1, OFF_WAKE_FLAGS, 32'hff);
    rd(OFF_WAKE_FLAGS, 17'h00ff);
    bus(1'b1, OFF_WAKE_FLAGS, {26'h0, k});
    rd(OFF_WAKE_FLAGS, {9'h0, 2'b11, k});
    bus(1'b1, OFF_WAKE_FLAGS, 32'h0);
    bus(1'b1, OFF_EXT_FLAGS, 32'h0);
    rd(OFF_EXT_FLAGS, 17'h0000);
    cmp({irq, wake_irq_req, ext0_irq_req}, 17'h0);
    // mid-run reset held the shortest allowed span
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    cmp({irq, cpu_run, interrupt_mask}, 17'h0);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(OFF_WAKE_FLAGS, 17'h00c0);
    rd(OFF_WAKE_CONFIG, 17'h0000);
    final_report();
  end
endmodule : wake_irq_flags_reset_entry_tb

// >>> verification/wake_irq_monitor.sv
// port checker for the wake flags and reset entry block
`timescale 1ns/1ps
module wake_irq_monitor
  import wake_irq_pkg::*;
#(
  parameter int          NW        = NUM_WAKE,
  parameter logic [15:0] VEC_VALUE = 16'h0100
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              avs_response_err,
  input wire logic [NW-1:0]     wake_line,
  input wire logic              ext_int_line_0,
  input wire logic              irq,
  input wire logic              wake_irq_req,
  input wire logic              ext0_irq_req,
  input wire logic              interrupt_mask,
  input wire logic [15:0]       program_counter,
  input wire logic              cpu_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // single level output is the or of both request paths
  a_irq_level: assert property (irq == (wake_irq_req | ext0_irq_req))
    else $error("irq differs from requests");
  // one wait state, then the answer
  a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_idle_nowait: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  // entry sequence: mask set on the second edge after release
  a_mask_step: assert property ($rose(rst_n) |-> !interrupt_mask ##1 !interrupt_mask ##1 interrupt_mask)
    else $error("mask not set in time");
  a_entry_time: assert property ($rose(rst_n) |-> !cpu_run [*6] ##1 cpu_run)
    else $error("run start off time");
  a_pc_vector: assert property ($rose(cpu_run) |-> program_counter == VEC_VALUE)
    else $error("program counter not the vector");
  a_mask_run: assert property (cpu_run |-> interrupt_mask)
    else $error("running without mask");
  // once running, nothing but reset stops it
  a_run_holds: assert property (cpu_run |=> cpu_run && $stable(program_counter))
    else $error("run dropped or pc moved");
endmodule : wake_irq_monitor

bind wake_irq_flags_reset_entry wake_irq_monitor #(.NW(NW), .VEC_VALUE(VEC_VALUE)) i_mon (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .wake_line(wake_line), .ext_int_line_0(ext_int_line_0),
  .irq(irq), .wake_irq_req(wake_irq_req), .ext0_irq_req(ext0_irq_req),
  .interrupt_mask(interrupt_mask), .program_counter(program_counter), .cpu_run(cpu_run));

// >>> verification/wake_pin_model.sv
// external pin model for the wake and line-0 inputs
`timescale 1ns/1ps
module wake_pin_model
  import wake_irq_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [NUM_WAKE-1:0] want_wake,
  input  wire logic                want_ext,
  output logic      [NUM_WAKE-1:0] wake_line = '0,
  output logic                     ext_int_line_0 = 1'b0
);
  // pins move just after a rising edge; the synchroniser absorbs the phase
  always @(posedge clk) begin
    wake_line      <= want_wake;
    ext_int_line_0 <= want_ext;
  end
endmodule : wake_pin_model
